// File: inc/wmx_pkg.sv
package wmx_pkg;

	// Word sizing and word clock shape
	localparam logic [2:0] WMX_LAST_32    = 3'h3;
	localparam logic [2:0] WMX_LAST_40    = 3'h4;
	localparam logic [2:0] WMX_POS_LAST   = 3'h4;
	localparam logic [2:0] WMX_POS_SKIP32 = 3'h1;
	localparam logic [2:0] WMX_WCLK_HIGH  = 3'h2;
	localparam int         WMX_BYTE_W     = 8;

	// Command field encodings
	localparam logic [4:0] WMX_IDLE_CMD   = 5'h15;
	localparam logic [1:0] WMX_GRP_D10    = 2'h1;
	localparam logic [1:0] WMX_GRP_D21    = 2'h2;
	localparam logic [2:0] WMX_N_KSPECIAL = 3'h4;
	localparam logic [2:0] WMX_POS_FILL   = 3'h2;

	// Special and fixed characters, y in bits 7:5, x in bits 4:0
	localparam logic [7:0] WMX_K28_5 = 8'hbc;
	localparam logic [7:0] WMX_K23_7 = 8'hf7;
	localparam logic [7:0] WMX_K27_7 = 8'hfb;
	localparam logic [7:0] WMX_K29_7 = 8'hfd;
	localparam logic [7:0] WMX_K30_7 = 8'hfe;
	localparam logic [7:0] WMX_D10_5 = 8'haa;
	localparam logic [7:0] WMX_D21_5 = 8'hb5;
	localparam logic [4:0] WMX_X21   = 5'h15;
	localparam logic [4:0] WMX_X28   = 5'h1c;
	localparam logic [2:0] WMX_Y4    = 3'h4;
	localparam logic [2:0] WMX_Y5    = 3'h5;

	// 8B/10B tables, codes valid for negative disparity, except WMX_A7_POS, which is used at positive disparity
	localparam logic [0:31][5:0] WMX_E6 = {
		6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
		6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
	localparam logic [0:7][3:0] WMX_E4 = {
		4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
	localparam logic [5:0] WMX_K28_6  = 6'h0f;
	localparam logic [3:0] WMX_A7_NEG = 4'h7;
	localparam logic [3:0] WMX_A7_POS = 4'h8;
	localparam logic [4:0] WMX_X7     = 5'h07;
	localparam logic [2:0] WMX_Y3     = 3'h3;
	localparam logic [2:0] WMX_Y7     = 3'h7;
	localparam logic [4:0] WMX_X11    = 5'h0b;
	localparam logic [4:0] WMX_X13    = 5'h0d;
	localparam logic [4:0] WMX_X14    = 5'h0e;
	localparam logic [4:0] WMX_X17    = 5'h11;
	localparam logic [4:0] WMX_X18    = 5'h12;
	localparam logic [4:0] WMX_X20    = 5'h14;

endpackage

// File: logic/wmx_word_mux.sv
`timescale 1ns/1ps
module wmx_word_mux (
	// Clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_resetn,
	// Host side
	input  wire logic        i_input_strobe,
	input  wire logic [39:0] i_parallel_word_in,
	input  wire logic [4:0]  i_command_field,
	input  wire logic        i_width_40,
	output logic             o_input_ready,
	// Multi-device reset
	input  wire logic        i_async_reset_in,
	input  wire logic        i_word_clock_reset_in,
	output logic             o_synced_reset_out,
	// Serializer side
	output logic [9:0]       o_codeword,
	output logic             o_word_clock_out
);
	import wmx_pkg::*;

	typedef struct packed {
		logic        str_s1;
		logic        str_s2;
		logic        str_s3;
		logic [44:0] din_s1;
		logic [44:0] din_s2;
		logic        ars_s1;
		logic        ars_s2;
		logic        wcr_s1;
		logic        wcr_s2;
		logic        in_full;
		logic [39:0] in_data;
		logic [4:0]  in_cmd;
		logic [39:0] mux_data;
		logic [4:0]  mux_cmd;
		logic        low_all;
		logic [2:0]  cnt;
		logic [7:0]  enc_byte;
		logic        enc_k;
		logic        enc_dual;
		logic        rd;
		logic [9:0]  code;
		logic        wclk;
		logic        ready;
	} wmx_state_t;

	localparam wmx_state_t WMX_RESET = '{mux_cmd: WMX_IDLE_CMD, wclk: 1'b1, ready: 1'b1,
		default: '0};

	wmx_state_t st;
	wmx_state_t next_st;

	// Returns {k, dual, byte} for lane pos under the command field
	function automatic logic [9:0] wmx_lane(input logic [4:0] cmd, input logic [39:0] data,
		input logic [2:0] pos);
		logic [7:0] d;
		logic [9:0] r;
		d = data[(WMX_POS_LAST - pos) * WMX_BYTE_W +: WMX_BYTE_W];
		r = {2'b00, d};
		if (cmd[4:3] == WMX_GRP_D10 || cmd[4:3] == WMX_GRP_D21) begin
			if (pos < WMX_POS_FILL)
				r = {2'b10, WMX_K28_5};
			else if (pos == WMX_POS_FILL)
				r = {2'b01, (cmd[4:3] == WMX_GRP_D10) ? WMX_D10_5 : WMX_D21_5};
			else
				r = {2'b00, cmd[2:0], WMX_X21};
		end else if (cmd[2:0] < WMX_N_KSPECIAL) begin
			if (pos < cmd[2:0])
				r = {2'b10, WMX_K28_5};
		end else if (pos <= WMX_POS_FILL) begin
			unique case (cmd[1:0])
				2'h0: r = {2'b10, WMX_K23_7};
				2'h1: r = {2'b10, WMX_K27_7};
				2'h2: r = {2'b10, WMX_K29_7};
				2'h3: r = {2'b10, WMX_K30_7};
			endcase
		end
		return r;
	endfunction

	// Returns {rd_after, abcdeifghj}; rd true means positive disparity
	function automatic logic [10:0] wmx_encode(input logic [7:0] b, input logic k,
		input logic rd);
		logic [5:0] c6;
		logic [3:0] c4;
		logic       mid;
		logic       alt;
		c6 = (k && b[4:0] == WMX_X28) ? WMX_K28_6 : WMX_E6[b[4:0]];
		if (rd && ($countones(c6) != 3 || b[4:0] == WMX_X7))
			c6 = ~c6;
		mid = ($countones(c6) == 3) ? rd : ~rd;
		alt = (b[7:5] == WMX_Y7) && (k
			|| (!mid && (b[4:0] == WMX_X17 || b[4:0] == WMX_X18 || b[4:0] == WMX_X20))
			|| (mid && (b[4:0] == WMX_X11 || b[4:0] == WMX_X13 || b[4:0] == WMX_X14)));
		c4 = WMX_E4[b[7:5]];
		if (alt)
			c4 = mid ? WMX_A7_POS : WMX_A7_NEG;
		else if (mid && ($countones(c4) != 2 || b[7:5] == WMX_Y3))
			c4 = ~c4;
		else if (!mid && k && $countones(c4) == 2 && b[7:5] != WMX_Y3)
			c4 = ~c4;
		return {($countones(c4) == 2) ? mid : ~mid, c6, c4};
	endfunction

	logic       hold;
	logic       edge_seen;
	logic       low_now;
	logic [2:0] last;
	logic [2:0] pos;
	logic [9:0] lane;
	logic [7:0] enc_in;
	logic [10:0] enc_out;

	always_comb begin
		next_st = st;
		// Pins other than i_width_40 and i_resetn pass two flops; the second stage feeds logic, and the strobe adds a third for its edge detect
		next_st.str_s1 = i_input_strobe;
		next_st.str_s2 = st.str_s1;
		next_st.str_s3 = st.str_s2;
		next_st.din_s1 = {i_command_field, i_parallel_word_in};
		next_st.din_s2 = st.din_s1;
		next_st.ars_s1 = i_async_reset_in;
		next_st.ars_s2 = st.ars_s1;
		next_st.wcr_s1 = i_word_clock_reset_in;
		next_st.wcr_s2 = st.wcr_s1;
		hold      = st.wcr_s2 | st.ars_s2;
		edge_seen = st.str_s2 & ~st.str_s3;
		low_now   = st.low_all & ~st.str_s2;
		last      = i_width_40 ? WMX_LAST_40 : WMX_LAST_32;
		// 32-bit words skip the leading lane of the 40-bit layout
		pos       = i_width_40 ? st.cnt : st.cnt + WMX_POS_SKIP32;

		// Input register capture, ignored while still full
		if (edge_seen && !st.in_full) begin
			next_st.in_full = 1'b1;
			next_st.in_cmd  = st.din_s2[44:40];
			next_st.in_data = st.din_s2[39:0];
		end

		// Byte sequencing and latch handover at the word boundary
		lane = wmx_lane(st.mux_cmd, st.mux_data, pos);
		next_st.enc_k    = lane[9];
		next_st.enc_dual = lane[8];
		next_st.enc_byte = lane[7:0];
		next_st.low_all  = low_now;
		if (st.cnt == last) begin
			next_st.cnt     = '0;
			next_st.low_all = ~st.str_s2;
			if (st.in_full && !low_now) begin
				next_st.mux_data = st.in_data;
				next_st.mux_cmd  = st.in_cmd;
				next_st.in_full  = 1'b0;
			end else begin
				next_st.mux_cmd = WMX_IDLE_CMD;
			end
		end else begin
			next_st.cnt = st.cnt + 3'h1;
		end

		if (hold) begin
			next_st.cnt     = '0;
			next_st.in_full = 1'b0;
			next_st.mux_cmd = WMX_IDLE_CMD;
			next_st.low_all = 1'b0;
		end

		// Dual characters: .4 only for 32-bit words, when it pulls positive disparity back negative; 40-bit words always use .5
		enc_in = st.enc_byte;
		if (st.enc_dual)
			enc_in[7:5] = (st.rd && !i_width_40) ? WMX_Y4 : WMX_Y5;
		enc_out      = wmx_encode(enc_in, st.enc_k, st.rd);
		next_st.rd   = enc_out[10];
		next_st.code = enc_out[9:0];
		next_st.wclk  = next_st.cnt < WMX_WCLK_HIGH;
		next_st.ready = ~next_st.in_full;
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn)
			st <= WMX_RESET;
		else
			st <= next_st;
	end

	assign o_input_ready      = st.ready;
	assign o_synced_reset_out = st.ars_s2;
	assign o_codeword         = st.code;
	assign o_word_clock_out   = st.wclk;

	default clocking cb @(posedge i_core_clk); endclocking

	property p_ready_drop;
		disable iff (!i_resetn || hold)
		(edge_seen && o_input_ready) |=> !o_input_ready ##0 st.in_data == $past(st.din_s2[39:0]);
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("capture missed");

	property p_ignore_full;
		disable iff (!i_resetn || hold)
		(edge_seen && !o_input_ready && st.cnt != last) |=> $stable(st.in_data);
	endproperty
	a_ignore_full: assert property (p_ignore_full) else $error("strobe not ignored");

	property p_div4;
		disable iff (!i_resetn || hold || i_width_40)
		$rose(o_word_clock_out) |-> ##4 $rose(o_word_clock_out);
	endproperty
	a_div4: assert property (p_div4) else $error("word clock not div 4");

	property p_div5;
		disable iff (!i_resetn || hold || !i_width_40)
		$rose(o_word_clock_out) |-> ##5 $rose(o_word_clock_out);
	endproperty
	a_div5: assert property (p_div5) else $error("word clock not div 5");

	property p_empty_idle;
		disable iff (!i_resetn || hold)
		(st.cnt == last && !st.in_full) |=> st.mux_cmd == WMX_IDLE_CMD && st.cnt == 3'h0;
	endproperty
	a_empty_idle: assert property (p_empty_idle) else $error("no idle on empty");

	property p_idle_lead;
		disable iff (!i_resetn || hold)
		(st.cnt == 3'h0 && st.mux_cmd == WMX_IDLE_CMD) |=> st.enc_byte == WMX_K28_5 && st.enc_k;
	endproperty
	a_idle_lead: assert property (p_idle_lead) else $error("idle not led by K28.5");

	// The reset codeword is all zeros, so the first edge after release is skipped
	property p_balance;
		disable iff (!i_resetn)
		$past(i_resetn) |-> $countones(o_codeword) inside {4, 5, 6};
	endproperty
	a_balance: assert property (p_balance) else $error("codeword unbalanced");

	property p_handover;
		disable iff (!i_resetn || hold)
		(st.cnt == last && st.in_full && !low_now) |=> o_input_ready
			##0 st.mux_data == $past(st.in_data);
	endproperty
	a_handover: assert property (p_handover) else $error("word not moved");

	property p_dual_neg;
		disable iff (!i_resetn || i_width_40)
		st.enc_dual |=> !st.rd;
	endproperty
	a_dual_neg: assert property (p_dual_neg) else $error("dual left positive");

	property p_hold;
		disable iff (!i_resetn)
		hold |=> st.cnt == 3'h0 && o_word_clock_out;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not applied");

endmodule

// File: tb/wmx_ser_model.sv
`timescale 1ns/1ps
// Serializer stand-in: takes one codeword per byte clock, bit 9 goes first
module wmx_ser_model (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_resetn,
	// From the encoder
	input  wire logic [9:0] i_codeword,
	// Captured stream
	output logic [9:0]      o_code,
	output logic            o_valid
);
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_code  <= 10'h3ff;
			o_valid <= 1'b0;
		end else begin
			o_code  <= i_codeword;
			o_valid <= 1'b1;
		end
	end
endmodule

// File: tb/word_mux_8b10b_encoder_test.sv
`timescale 1ns/1ps
module word_mux_8b10b_encoder_test;
	import wmx_pkg::*;
	localparam logic [49:0] IDLE40 = {10'h0fa, 10'h305, 10'h2aa, 10'h2aa, 10'h2aa};
	localparam logic [49:0] IDLE32 = {10'h000, 10'h0fa, 10'h2a2, 10'h2aa, 10'h2aa};
	localparam logic [9:0]  K23_7_NEG = 10'h3a8;
	localparam logic [4:0]  CMD_K23   = 5'h04;
	// Plain data, the idle command, a K23.7 command and a data command of the upper section
	localparam logic [0:7][4:0] CMDS = {5'h00, 5'h00, 5'h00, WMX_IDLE_CMD, 5'h00, CMD_K23,
		5'h18, 5'h00};
	logic        clk = 0;
	logic        rstn;
	logic        stb;
	logic [39:0] word;
	logic [4:0]  cmd;
	logic        w40;
	logic        arst;
	logic        wrst;
	logic        rdy;
	logic        srst;
	logic [9:0]  code;
	logic        wclk;
	logic [9:0]  ser_code;
	logic        ser_v;
	logic [49:0] exp_q[$];
	logic [49:0] grp;
	int          mismatches = 0;
	int          cmp_count = 0;
	int          idx;
	int          highs;
	int          nb;
	int          n;
	bit          mon_on = 0;
	bit          synced;

	always #50 clk = ~clk;

	wmx_word_mux u_dut (
		.i_core_clk(clk), .i_resetn(rstn), .i_input_strobe(stb),
		.i_parallel_word_in(word), .i_command_field(cmd), .i_width_40(w40),
		.o_input_ready(rdy), .i_async_reset_in(arst), .i_word_clock_reset_in(wrst),
		.o_synced_reset_out(srst), .o_codeword(code), .o_word_clock_out(wclk));

	wmx_ser_model u_ser (
		.i_core_clk(clk), .i_resetn(rstn), .i_codeword(code),
		.o_code(ser_code), .o_valid(ser_v));

	task automatic check(input string name, input logic [49:0] seen, input logic [49:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Only disparity-neutral bytes, so the expected code needs no running state
	function logic [7:0] rbyte;
		logic [4:0] x;
		logic [2:0] y;
		do x = 5'($urandom); while ($countones(WMX_E6[x]) != 3 || x == WMX_X7);
		do y = 3'($urandom); while ($countones(WMX_E4[y]) != 2 || y == WMX_Y3);
		return {y, x};
	endfunction

	task wait_rdy(input logic lvl);
		n = 0;
		while (rdy !== lvl && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("input_ready", rdy, lvl);
		if (rdy !== lvl) conclude();
	endtask

	task send(input logic [4:0] c);
		logic [49:0] e;
		@(negedge clk);
		wait_rdy(1'b1);
		for (int i = 0; i < 5; i++) begin
			word[8*i +: 8] = rbyte();
			e[10*i +: 10] = {WMX_E6[word[8*i +: 5]], WMX_E4[word[8*i+5 +: 3]]};
			// Lanes 0 to 2 carry K23.7, which leaves negative disparity as it found it
			if (c == CMD_K23 && i >= 2) e[10*i +: 10] = K23_7_NEG;
		end
		if (!w40) e[49:40] = 10'h000;
		if (c != WMX_IDLE_CMD) exp_q.push_back(e);
		cmd = c;
		// Strobe moves on the falling edge, in step with the byte clock
		stb = 1'b1;
		wait_rdy(1'b0);
		stb = 1'b0;
	endtask

	// Frames the stream on K28.5 and checks each word against the notes
	always @(negedge clk) begin
		nb = w40 ? 5 : 4;
		if (!mon_on) begin
			synced = 0;
		end else if (ser_v) begin
			if (!synced && ser_code === 10'h0fa) begin
				synced = 1;
				idx = 0;
			end
			if (synced) begin
				if (idx == 0) begin
					grp = '0;
					highs = 0;
				end
				grp = {grp[39:0], ser_code};
				highs += int'(wclk);
				idx++;
				if (idx == nb) begin
					idx = 0;
					check("word_clock_high", 50'(highs), 50'(WMX_WCLK_HIGH));
					if (grp[10*nb-1 -: 10] === 10'h0fa)
						check("idle", grp, w40 ? IDLE40 : IDLE32);
					else if (exp_q.size() == 0)
						check("stray_word", grp, '1);
					else
						check("word", grp, exp_q.pop_front());
				end
			end
		end
	end

	initial begin
		{rstn, stb, word, cmd, w40, arst, wrst} = '0;
		void'($urandom(88));
		for (int k = 0; k < 2; k++) begin
			rstn = 1'b0;
			w40 = (k == 0);
			repeat (12) @(negedge clk);
			check("ready_in_reset", rdy, 1'b1);
			rstn = 1'b1;
			mon_on = 1;
			repeat (3) @(negedge clk);
			for (int i = 0; i < 8; i++) send(CMDS[i]);
			n = 0;
			while (exp_q.size() != 0 && n < 200) begin
				@(negedge clk);
				n++;
			end
			check("pending_words", 50'(exp_q.size()), 50'h0);
			if (exp_q.size() != 0) conclude();
			repeat (12) @(negedge clk);
			mon_on = 0;
		end
		arst = 1'b1;
		@(negedge clk);
		check("synced_reset_early", srst, 1'b0);
		@(negedge clk);
		check("synced_reset", srst, 1'b1);
		repeat (6) @(negedge clk);
		check("wclk_held", wclk, 1'b1);
		arst = 1'b0;
		wrst = 1'b1;
		repeat (8) @(negedge clk);
		check("wclk_held_wrst", wclk, 1'b1);
		check("ready_held_wrst", rdy, 1'b1);
		conclude();
	end
endmodule
